// [rtl/sxc_top.sv]
// Top: serial channel zero clock-source selection with its AXI4-Lite register slave
//
// Notes on behaviour
// - Bit 7 of the extension register enables the select function.
// - Select enable acts only in synchronous mode with external clock control set.
// - Enabled select and pin high: transmit output floats, serial clock held high.
// - Base select bit: 0 gives 16x, 1 gives 8x transfer rate base clock.
// - Base select bit acts only in asynchronous mode, ignored when synchronous.
// - Source code 000 is external clock input; code 011 is reserved.
// - Source field acts only with external clock control set and asynchronous mode.
// - Average-rate codes fix the oversampling multiple and ignore the base select bit.
// - Codes 001 and 010 give 115.152 kbps at 16x and 460.606 kbps at 8x.
// - Code 100 uses AND of timer channel one and two outputs as base clock.
// - Codes 101 and 110 give 115.196 and 460.784 kbps, both 16x oversampling.
// - Code 111 gives 720 kbps average rate with 8x oversampling base clock.
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module sxc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [sxc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sxc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clock_pin,
	input wire logic select_port_pin,
	input wire logic timer1_output,
	input wire logic timer2_output,
	input wire logic serial_mode_sync,
	input wire logic external_clock_ctrl,
	input wire logic txd_core,
	output logic transmit_data_out,
	output logic transmit_data_oe,
	output logic base_clk_tick,
	output logic base_x8,
	output logic sck_tick,
	output logic sck_forced_high
);
	import sxc_pkg::*;

	localparam int unsigned NSYNC = 4;
	localparam int unsigned SY_SEL = 0;
	localparam int unsigned SY_T1 = 1;
	localparam int unsigned SY_T2 = 2;
	localparam int unsigned SY_EXT = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic is_avg(input logic [SRC_W-1:0] code);
		case (code)
			SRC_AVG_115K_LO, SRC_AVG_460K_LO, SRC_AVG_115K_HI,
			SRC_AVG_460K_HI, SRC_AVG_720K_HI: is_avg = 1'b1;
			default: is_avg = 1'b0;
		endcase
	endfunction

	function automatic logic avg_x8(input logic [SRC_W-1:0] code);
		case (code)
			SRC_AVG_460K_LO, SRC_AVG_720K_HI: avg_x8 = 1'b1;
			default: avg_x8 = 1'b0;
		endcase
	endfunction

	function automatic logic [ACC_W-1:0] avg_inc(input logic [SRC_W-1:0] code);
		case (code)
			SRC_AVG_115K_LO: avg_inc = acc_inc(longint'(RATE_115K_LO_BPS) * OVS_16);
			SRC_AVG_460K_LO: avg_inc = acc_inc(longint'(RATE_460K_LO_BPS) * OVS_8);
			SRC_AVG_115K_HI: avg_inc = acc_inc(longint'(RATE_115K_HI_BPS) * OVS_16);
			SRC_AVG_460K_HI: avg_inc = acc_inc(longint'(RATE_460K_HI_BPS) * OVS_16);
			SRC_AVG_720K_HI: avg_inc = acc_inc(longint'(RATE_720K_HI_BPS) * OVS_8);
			default: avg_inc = '0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register state

	logic sel_en_r;
	logic base_sel_r;
	logic [SRC_W-1:0] src_r;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain and input synchronisers

	sxc_link_if lk_if ();

	sxc_link u_link (
		.serial_clock_pin(serial_clock_pin),
		.aresetn(aresetn),
		.lk(lk_if.link)
	);

	logic [NSYNC-1:0] raw_in;
	logic [2:0] sy_r [NSYNC];
	logic [NSYNC-1:0] flt_r;
	logic [NSYNC-1:0] flt_prev_r;

	assign raw_in = {lk_if.edge_tgl, timer2_output, timer1_output, select_port_pin};

	// Three stages; a new level is taken only when stages two and three agree
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NSYNC; i++) begin
			if (!aresetn) begin
				sy_r[i] <= 3'h0;
				flt_r[i] <= 1'b0;
				flt_prev_r[i] <= 1'b0;
			end else begin
				sy_r[i] <= {sy_r[i][1:0], raw_in[i]};
				if (sy_r[i][1] == sy_r[i][2]) begin
					flt_r[i] <= sy_r[i][2];
				end
				flt_prev_r[i] <= flt_r[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	logic sync_ext;
	logic async_ext;
	logic sel_active;
	logic ext_edge;
	logic tmr_edge;
	logic src_avg;

	assign sync_ext = serial_mode_sync & external_clock_ctrl;
	assign async_ext = ~serial_mode_sync & external_clock_ctrl;
	assign sel_active = sel_en_r & sync_ext & flt_r[SY_SEL];
	assign ext_edge = flt_r[SY_EXT] ^ flt_prev_r[SY_EXT];
	// Rising edge of the AND of both timer outputs
	assign tmr_edge = flt_r[SY_T1] & flt_r[SY_T2] & ~(flt_prev_r[SY_T1] & flt_prev_r[SY_T2]);
	assign src_avg = async_ext & is_avg(src_r);

	////////////////////////////////////////////////////////////////////////////////
	// Average-rate pulse gate

	logic [ACC_W-1:0] acc_r;
	logic [ACC_W:0] acc_sum;

	assign acc_sum = {1'b0, acc_r} + {1'b0, avg_inc(src_r)};

	// Carry out of the accumulator passes one system clock pulse
	always_ff @(posedge aclk) begin
		if (!aresetn || !src_avg) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_sum[ACC_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Base clock and multiple

	logic base_tick_nxt;

	always_comb begin
		base_tick_nxt = 1'b0;
		if (async_ext) begin
			case (src_r)
				SRC_EXT_CLK: base_tick_nxt = ext_edge;
				SRC_TIMER_AND: base_tick_nxt = tmr_edge;
				SRC_RESERVED: base_tick_nxt = 1'b0;
				default: base_tick_nxt = acc_sum[ACC_W];
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_clk_tick <= 1'b0;
		end else begin
			base_clk_tick <= base_tick_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_x8 <= 1'b0;
		end else if (serial_mode_sync) begin
			base_x8 <= 1'b0;
		end else if (src_avg) begin
			base_x8 <= avg_x8(src_r);
		end else begin
			base_x8 <= base_sel_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Select function: transmit float and serial clock hold

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmit_data_out <= 1'b1;
			transmit_data_oe <= 1'b0;
			sck_forced_high <= 1'b0;
			sck_tick <= 1'b0;
		end else begin
			transmit_data_out <= txd_core;
			transmit_data_oe <= ~sel_active;
			sck_forced_high <= sel_active;
			// Held high means no edges reach the core
			sck_tick <= sync_ext & ext_edge & ~sel_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;

	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
	assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

	// Address and data are taken in either order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_en_r <= EXT_MODE_RST[SEL_EN_BIT];
			base_sel_r <= EXT_MODE_RST[BASE_SEL_BIT];
			src_r <= EXT_MODE_RST[SRC_LSB +: SRC_W];
		end else if (wr_go && aw_addr_r[ADDR_W-1:2] == REG_EXT_MODE_OFS[ADDR_W-1:2]
				&& w_strb_r[0]) begin
			sel_en_r <= w_data_r[SEL_EN_BIT];
			base_sel_r <= w_data_r[BASE_SEL_BIT];
			src_r <= w_data_r[SRC_LSB +: SRC_W];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr_r[ADDR_W-1:2] == REG_EXT_MODE_OFS[ADDR_W-1:2]
					|| aw_addr_r[ADDR_W-1:2] == REG_STATUS_OFS[ADDR_W-1:2]) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	logic [31:0] ext_mode_rd;
	logic [31:0] status_rd;

	always_comb begin
		ext_mode_rd = 32'h0;
		// Reserved bits 6 to 4 read as zero
		ext_mode_rd[SEL_EN_BIT] = sel_en_r;
		ext_mode_rd[BASE_SEL_BIT] = base_sel_r;
		ext_mode_rd[SRC_LSB +: SRC_W] = src_r;
		status_rd = 32'h0;
		status_rd[ST_SEL_ACTIVE_BIT] = sel_active;
		status_rd[ST_SRC_ACTIVE_BIT] = async_ext;
		status_rd[ST_BASE_X8_BIT] = base_x8;
		status_rd[ST_EXT_LEVEL_BIT] = flt_r[SY_EXT];
	end

	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			if (s_axi_araddr[ADDR_W-1:2] == REG_EXT_MODE_OFS[ADDR_W-1:2]) begin
				s_axi_rdata <= ext_mode_rd;
				s_axi_rresp <= RESP_OKAY;
			end else if (s_axi_araddr[ADDR_W-1:2] == REG_STATUS_OFS[ADDR_W-1:2]) begin
				s_axi_rdata <= status_rd;
				s_axi_rresp <= RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= RESP_DECERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [rtl/sxc_pkg.sv]
// Package: register map, field layout and clock-source codes of the serial clock extension
package sxc_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CLK_HZ = 200_000_000;

	// Register byte offsets
	localparam logic [7:0] REG_EXT_MODE_OFS = 8'h00;
	localparam logic [7:0] REG_STATUS_OFS = 8'h04;

	// Extension mode register layout
	localparam int unsigned SEL_EN_BIT = 7;
	localparam int unsigned BASE_SEL_BIT = 3;
	localparam int unsigned SRC_LSB = 0;
	localparam int unsigned SRC_W = 3;
	localparam logic [7:0] EXT_MODE_RST = 8'h00;

	// Status register layout
	localparam int unsigned ST_SEL_ACTIVE_BIT = 0;
	localparam int unsigned ST_SRC_ACTIVE_BIT = 1;
	localparam int unsigned ST_BASE_X8_BIT = 2;
	localparam int unsigned ST_EXT_LEVEL_BIT = 3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		SRC_EXT_CLK = 3'h0,
		SRC_AVG_115K_LO = 3'h1,
		SRC_AVG_460K_LO = 3'h2,
		SRC_RESERVED = 3'h3,
		SRC_TIMER_AND = 3'h4,
		SRC_AVG_115K_HI = 3'h5,
		SRC_AVG_460K_HI = 3'h6,
		SRC_AVG_720K_HI = 3'h7
	} sxc_src_t;

	// Average rates in bit/s and oversampling multiples
	localparam int unsigned RATE_115K_LO_BPS = 115_152;
	localparam int unsigned RATE_460K_LO_BPS = 460_606;
	localparam int unsigned RATE_115K_HI_BPS = 115_196;
	localparam int unsigned RATE_460K_HI_BPS = 460_784;
	localparam int unsigned RATE_720K_HI_BPS = 720_000;
	localparam int unsigned OVS_16 = 16;
	localparam int unsigned OVS_8 = 8;

	// Fractional accumulator width for the average-rate pulse gate
	localparam int unsigned ACC_W = 24;

	function automatic logic [ACC_W-1:0] acc_inc(input longint unsigned hz);
		longint unsigned q;
		q = (hz << ACC_W) / longint'(CLK_HZ);
		return q[ACC_W-1:0];
	endfunction

endpackage

// [rtl/sxc_link_if.sv]
// Interface: event toggle carried from the serial clock domain to the system domain
`timescale 1ns/1ps
`default_nettype none
interface sxc_link_if;
	logic edge_tgl;
	modport link (output edge_tgl);
	modport sys (input edge_tgl);
endinterface
`default_nettype wire

// [rtl/sxc_link.sv]
// Serial clock domain: flips a toggle on every rising edge of the external serial clock
`timescale 1ns/1ps
`default_nettype none
module sxc_link (
	input wire logic serial_clock_pin,
	input wire logic aresetn,
	sxc_link_if.link lk
);
	import sxc_pkg::*;

	logic [1:0] rst_sy_r;
	logic tgl_r;

	// Asserted at once, released on the pin clock: the pin clock may be idle during reset
	always_ff @(posedge serial_clock_pin or negedge aresetn) begin
		if (!aresetn) begin
			rst_sy_r <= 2'h0;
		end else begin
			rst_sy_r <= {rst_sy_r[0], 1'b1};
		end
	end

	// One toggle per external edge, so the system side sees each edge once
	always_ff @(posedge serial_clock_pin) begin
		if (!rst_sy_r[1]) begin
			tgl_r <= 1'b0;
		end else begin
			tgl_r <= ~tgl_r;
		end
	end

	assign lk.edge_tgl = tgl_r;
endmodule
`default_nettype wire

// [verification/sxc_peer.sv]
// Far-side model: external serial clock source and timer channel outputs
`timescale 1ns/1ps
`default_nettype none
module sxc_peer (
	input wire logic clk_run,
	output logic serial_clock_pin,
	output logic timer1_output,
	output logic timer2_output
);
	// Clock stands still low between frames
	initial begin
		serial_clock_pin = 1'h0;
		#3.3;
		forever #15 serial_clock_pin = clk_run ? !serial_clock_pin : 1'h0;
	end
	// Timer pins act purely as outputs; timer one high 20 ns, low 40 ns; timer two toggles every 60 ns
	initial begin
		timer1_output = 1'h0;
		forever begin
			timer1_output = 1'h1;
			#20 timer1_output = 1'h0;
			#40;
		end
	end
	initial begin
		timer2_output = 1'h1;
		forever #60 timer2_output = !timer2_output;
	end
endmodule
`default_nettype wire

// [verification/sxc_monitor.sv]
// Checker: port-level properties of the serial clock extension
`timescale 1ns/1ps
`default_nettype none
module sxc_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic serial_mode_sync,
	input wire logic external_clock_ctrl,
	input wire logic select_port_pin,
	input wire logic txd_core,
	input wire logic transmit_data_out,
	input wire logic transmit_data_oe,
	input wire logic base_clk_tick,
	input wire logic base_x8,
	input wire logic sck_tick,
	input wire logic sck_forced_high
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Eight steady cycles outlast the synchroniser and output stage
	sequence s_async; !serial_mode_sync [*8]; endsequence
	sequence s_sync; serial_mode_sync [*8]; endsequence
	sequence s_pin_low; !select_port_pin [*8]; endsequence
	sequence s_no_ext; !external_clock_ctrl [*8]; endsequence
	a_tx_delay: assert property ($past(aresetn) |-> transmit_data_out == $past(txd_core))
		else $error("transmit output not one cycle behind core data");
	a_forced_oe_off: assert property (sck_forced_high |-> !transmit_data_oe)
		else $error("transmit output driven while clock forced high");
	a_forced_no_tick: assert property (sck_forced_high |-> !sck_tick)
		else $error("serial tick while clock forced high");
	a_async_no_sel: assert property (s_async |=> transmit_data_oe && !sck_forced_high)
		else $error("select function active in async mode");
	a_pin_low_drive: assert property (s_pin_low |=> transmit_data_oe && !sck_forced_high)
		else $error("select function active with pin low");
	a_sync_no_base: assert property (s_sync |=> !base_clk_tick && !base_x8)
		else $error("base clock activity in sync mode");
	a_no_ext_quiet: assert property (s_no_ext |=> !base_clk_tick && !sck_tick)
		else $error("tick without external clock control");
	a_tick_single: assert property (base_clk_tick |=> !base_clk_tick)
		else $error("base tick longer than one cycle");
endmodule
bind sxc_top sxc_monitor i_mon (.*);
`default_nettype wire

// [verification/sxc_top_test.sv]
// Testbench: register access, select function and base clock rates
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module sxc_top_test;
	import sxc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, txd_core = 1'h1, clk_run = 1'h0;
	logic serial_mode_sync = 1'h0, external_clock_ctrl = 1'h0, select_port_pin = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic serial_clock_pin, timer1_output, timer2_output, transmit_data_out, transmit_data_oe;
	logic base_clk_tick, base_x8, sck_tick, sck_forced_high, txd_past_r;
	int seed = 49856;
	int bad_count = 0, n_compared = 0, cyc = 0, btk = 0, stk = 0;
	always #2.5 aclk = !aclk;
	sxc_top i_dut (.*);
	sxc_peer i_peer (.*);
	always @(posedge aclk) begin
		rnd <= $random(seed);
		txd_core <= rnd[0];
		txd_past_r <= txd_core;
		btk <= btk + base_clk_tick;
		stk <= stk + sck_tick;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			summarize();
		end
	end
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'h0;
			if (w) s_axi_wvalid <= 1'h0;
		end while (!b);
		s_axi_bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'h0;
		end while (!v);
		s_axi_rready <= 1'h0;
	endtask
	// Ticks expected in a 5000-cycle window
	function automatic real exp_ticks(input logic [2:0] c);
		case (c)
			3'h0: return 5000.0 * 5.0 / 30.0;
			3'h4: return 5000.0 * 5.0 / 120.0;
			3'h5: return 115196.0 * 16.0 * 5000.0 / CLK_HZ;
			3'h6: return 460784.0 * 16.0 * 5000.0 / CLK_HZ;
			default: return 720000.0 * 8.0 * 5000.0 / CLK_HZ;
		endcase
	endfunction
	initial begin
		logic [31:0] d, w;
		logic [1:0] r;
		logic [2:0] c;
		logic b;
		int n, e;
		// Codes 001, 010 and 011 are never selected
		logic [2:0] codes [5];
		codes = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(REG_EXT_MODE_OFS, d, r);
		`CHK("ext_mode reset", {RESP_OKAY, 32'h0}, {r, d})
		axi_rd(REG_STATUS_OFS, d, r);
		`CHK("status reset", 32'h0, d)
		repeat (4) begin
			// Only codes 000 and 100 are written; the others are off limits here
			w = rnd & 32'h8C;
			axi_wr(REG_EXT_MODE_OFS, w, r);
			axi_rd(REG_EXT_MODE_OFS, d, r);
			`CHK("ext_mode", w, d)
		end
		axi_wr(8'h08, 32'h0, r);
		`CHK("unmapped wr", RESP_DECERR, r)
		axi_rd(8'h08, d, r);
		`CHK("unmapped rd", {RESP_DECERR, 32'h0}, {r, d})
		axi_wr(REG_STATUS_OFS, 32'hF, r);
		`CHK("status wr", RESP_OKAY, r)
		for (int i = 0; i < 16; i++) begin
			axi_wr(REG_EXT_MODE_OFS, {24'h0, i[3], 7'h0}, r);
			@(posedge aclk);
			serial_mode_sync <= i[2];
			external_clock_ctrl <= i[1];
			select_port_pin <= i[0];
			repeat (12) @(negedge aclk);
			`CHK("tx enable", !(&i[3:0]), transmit_data_oe)
			`CHK("clock forced", &i[3:0], sck_forced_high)
			`CHK("tx data", txd_past_r, transmit_data_out)
		end
		clk_run <= 1'h1;
		for (int p = 1; p >= 0; p--) begin
			@(posedge aclk);
			select_port_pin <= p[0];
			repeat (12) @(negedge aclk);
			n = stk;
			repeat (1200) @(negedge aclk);
			n = stk - n;
			e = p ? 0 : 200;
			`CHK("sck ticks near", 1'h1, n > e - 4 && n < e + 4)
		end
		foreach (codes[k]) begin
			c = codes[k];
			b = rnd[3];
			@(posedge aclk);
			serial_mode_sync <= 1'h0;
			clk_run <= (c == 3'h0);
			axi_wr(REG_EXT_MODE_OFS, {28'h0, b, c}, r);
			repeat (20) @(negedge aclk);
			`CHK("base x8", (c == 3'h7) | (c[1:0] == 2'h0 & b), base_x8)
			axi_rd(REG_STATUS_OFS, d, r);
			`CHK("status src", {(c == 3'h7) | (c[1:0] == 2'h0 & b), 2'h2}, d[2:0])
			n = btk;
			repeat (5000) @(negedge aclk);
			n = btk - n;
			e = $rtoi(exp_ticks(c));
			`CHK("base ticks near", 1'h1, n > e - 4 && n < e + 4)
		end
		@(posedge aclk);
		serial_mode_sync <= 1'h1;
		repeat (20) @(negedge aclk);
		n = btk;
		repeat (500) @(negedge aclk);
		`CHK("sync base ticks", 0, btk - n)
		`CHK("sync base x8", 1'h0, base_x8)
		summarize();
	end
endmodule
`default_nettype wire
